/* shared/spi_ctl_pkg.sv */
// Register map, field positions and pin carriers of the serial unit
package spi_ctl_pkg;
    localparam logic [7:0]  OFS_MAIN_CTL    = 8'h00;
    localparam logic [7:0]  OFS_IRQ_CTL     = 8'h04;
    localparam logic [7:0]  OFS_STATUS      = 8'h08;
    localparam logic [7:0]  OFS_DATA        = 8'h0c;
    localparam logic [7:0]  OFS_RX_CRC      = 8'h14;
    localparam logic [7:0]  OFS_I2S_CTL     = 8'h1c;

    localparam logic [15:0] MAIN_CTL_RESET  = 16'h0000;
    localparam logic [7:0]  IRQ_CTL_RESET   = 8'h00;
    localparam logic [7:0]  IRQ_CTL_MASK    = 8'he7;
    localparam logic [11:0] I2S_CTL_RESET   = 12'h000;
    localparam logic [11:0] I2S_CTL_MASK    = 12'hfbf;

    // Main control fields
    localparam int BIT_BIDIR     = 15;
    localparam int BIT_BIDIR_OUT = 14;
    localparam int BIT_CRC_EN    = 13;
    localparam int BIT_CRC_NEXT  = 12;
    localparam int BIT_FRAME16   = 11;
    localparam int BIT_RX_ONLY   = 10;
    localparam int BIT_SOFT_MODE = 9;
    localparam int BIT_SOFT_LVL  = 8;
    localparam int BIT_LSB_FIRST = 7;
    localparam int BIT_ENABLE    = 6;
    localparam int PSC_HI        = 5;
    localparam int PSC_LO        = 3;
    localparam int BIT_MASTER    = 2;
    localparam int BIT_CPOL      = 1;
    localparam int BIT_CPHA      = 0;

    // Interrupt control fields
    localparam int BIT_TXE_IE    = 7;
    localparam int BIT_RXNE_IE   = 6;
    localparam int BIT_ERR_IE    = 5;

    // Status fields
    localparam int BIT_BUSY      = 7;
    localparam int BIT_OVERRUN   = 6;
    localparam int BIT_CFG_FAULT = 5;
    localparam int BIT_CRC_ERR   = 4;
    localparam int BIT_UNDERRUN  = 3;
    localparam int BIT_CHANNEL   = 2;
    localparam int BIT_TX_EMPTY  = 1;
    localparam int BIT_RX_NEMPTY = 0;
    localparam logic [7:0] STATUS_RESET = 8'h02;

    // I2S control fields
    localparam int BIT_I2S_SEL   = 11;
    localparam int BIT_I2S_EN    = 10;
    localparam int BIT_I2S_MSTR  = 9;
    localparam int BIT_I2S_RX    = 8;
    localparam int BIT_I2S_CPOL  = 3;

    // Fixed half-period exponent for the I2S bit clock
    localparam logic [2:0] I2S_HALF_EXP = 3'h2;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic nss;
        logic ws;
    } pins_in_t;

    typedef struct packed {
        logic sck_out;
        logic sck_oe;
        logic mosi_out;
        logic mosi_oe;
        logic miso_out;
        logic miso_oe;
    } pins_out_t;
endpackage : spi_ctl_pkg

/* rtl/spi_ctl.sv */
// Control, status and serial engine of the combined SPI/I2S unit
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module spi_ctl
    import spi_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire pins_in_t    pins_in,
    output pins_out_t        pins_out,
    input  wire logic [15:0] crc_calc,
    output logic             irq
);
    typedef enum logic {IDLE, SHIFT} eng_state_t;

    function automatic logic bit_sel(input logic [15:0] w,
                                     input logic [3:0] idx,
                                     input logic lsb,
                                     input logic w16);
        logic [3:0] top;
        top = w16 ? 4'hf : 4'h7;
        bit_sel = lsb ? w[idx] : w[top - idx];
    endfunction : bit_sel

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        lane_merge = {be[1] ? wd[15:8] : old[15:8],
                      be[0] ? wd[7:0] : old[7:0]};
    endfunction : lane_merge

    // Pin synchronisers: three stages, accept when last two agree
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] sync3_r;
    logic [4:0] filt_r;
    logic [4:0] pin_vec;
    assign pin_vec = pins_in;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    filt_r[gi]  <= 1'b0;
                end else begin
                    sync1_r[gi] <= pin_vec[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        filt_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    logic sck_f;
    logic mosi_f;
    logic miso_f;
    logic nss_f;
    logic ws_f;
    assign {sck_f, mosi_f, miso_f, nss_f, ws_f} = filt_r;

    // Registers and flags
    logic [15:0] main_ctl_r;
    logic [7:0]  irq_ctl_r;
    logic [11:0] i2s_ctl_r;
    logic [15:0] tx_buf_r;
    logic [15:0] rx_buf_r;
    logic        tx_full_r;
    logic        rx_full_r;
    logic        overrun_r;
    logic        underrun_r;
    logic        cfg_fault_r;
    logic        crc_err_r;
    logic        channel_r;
    logic        ovr_armed_r;
    logic        cfg_armed_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic        irq_r;
    pins_out_t   pins_r;

    // Effective configuration: I2S mode overrides main control
    logic       i2s;
    logic       act;
    logic       mst;
    logic       cpol;
    logic       cpha;
    logic       lsb;
    logic       w16;
    logic       rx_only;
    logic       nss_lvl;
    logic [2:0] psc;
    assign i2s     = i2s_ctl_r[BIT_I2S_SEL];
    assign act     = i2s ? i2s_ctl_r[BIT_I2S_EN]
                         : main_ctl_r[BIT_ENABLE];
    assign mst     = i2s ? i2s_ctl_r[BIT_I2S_MSTR]
                         : main_ctl_r[BIT_MASTER];
    assign cpol    = i2s ? i2s_ctl_r[BIT_I2S_CPOL]
                         : main_ctl_r[BIT_CPOL];
    assign cpha    = i2s ? 1'b0 : main_ctl_r[BIT_CPHA];
    assign lsb     = i2s ? 1'b0 : main_ctl_r[BIT_LSB_FIRST];
    assign w16     = i2s | main_ctl_r[BIT_FRAME16];
    assign psc     = i2s ? I2S_HALF_EXP
                         : main_ctl_r[PSC_HI:PSC_LO];
    assign rx_only = i2s ? i2s_ctl_r[BIT_I2S_RX]
                   : main_ctl_r[BIT_BIDIR] ? !main_ctl_r[BIT_BIDIR_OUT]
                   : main_ctl_r[BIT_RX_ONLY];
    assign nss_lvl = main_ctl_r[BIT_SOFT_MODE] ? main_ctl_r[BIT_SOFT_LVL]
                                               : nss_f;

    logic fault_cond;
    logic selected;
    logic out_on_mosi;
    logic din;
    assign fault_cond  = !i2s && act && mst && !nss_lvl;
    assign selected    = i2s || !nss_lvl;
    assign out_on_mosi = i2s || mst;
    // Bidirectional and I2S use a single data line both ways
    assign din = ((i2s || main_ctl_r[BIT_BIDIR]) ? out_on_mosi
                                                 : !out_on_mosi)
                 ? mosi_f : miso_f;

    // Bus access
    logic acc;
    logic wr_acc;
    logic rd_acc;
    assign acc    = (read || write) && !wait_r;
    assign wr_acc = acc && write;
    assign rd_acc = acc && read;

    logic wr_main;
    logic wr_irq;
    logic wr_i2s;
    logic wr_data;
    logic wr_stat;
    logic rd_data;
    logic rd_stat;
    assign wr_main = wr_acc && address == OFS_MAIN_CTL;
    assign wr_irq  = wr_acc && address == OFS_IRQ_CTL;
    assign wr_i2s  = wr_acc && address == OFS_I2S_CTL;
    assign wr_data = wr_acc && address == OFS_DATA && |byteenable[1:0];
    assign wr_stat = wr_acc && address == OFS_STATUS;
    assign rd_data = rd_acc && address == OFS_DATA;
    assign rd_stat = rd_acc && address == OFS_STATUS;

    // Engine state
    eng_state_t  state_r;
    logic [4:0]  edge_cnt_r;
    logic [7:0]  div_cnt_r;
    logic        sck_int_r;
    logic        sck_prev_r;
    logic [15:0] tx_sh_r;
    logic [15:0] rx_sh_r;
    logic        dout_r;

    logic [4:0]  last_edge;
    logic [7:0]  div_lim;
    logic        sck_edge;
    logic        m_start;
    logic        s_start;
    logic        tick;
    logic        frame_end;
    logic        tx_load;
    logic        rx_store;
    assign last_edge = w16 ? 5'h1f : 5'h0f;
    assign div_lim   = (8'h01 << psc) - 8'h01;
    assign sck_edge  = sck_f != sck_prev_r;
    assign m_start   = state_r == IDLE && act && mst && !fault_cond
                       && (tx_full_r || rx_only);
    assign s_start   = state_r == IDLE && act && !mst && selected
                       && sck_edge;
    assign tick      = state_r == SHIFT
                       && (mst ? div_cnt_r == div_lim
                               : (sck_edge && selected));
    assign frame_end = (tick || s_start)
                       && (s_start ? 5'h00 : edge_cnt_r) == last_edge;
    assign tx_load   = (m_start || s_start) && tx_full_r;
    assign rx_store  = frame_end && !rx_full_r;

    logic [4:0]  k;
    logic [15:0] rx_next;
    assign k = s_start ? 5'h00 : edge_cnt_r;
    always_comb begin
        rx_next = rx_sh_r;
        if (!lsb) begin
            rx_next = {rx_sh_r[14:0], din};
        end else if (w16) begin
            rx_next = {din, rx_sh_r[15:1]};
        end else begin
            rx_next = {8'h00, din, rx_sh_r[7:1]};
        end
    end

    // Phase 0 samples on even edges, so the last edge adds no bit
    logic [15:0] rx_word;
    logic [15:0] rx_fmt;
    assign rx_word = (k[0] == cpha) ? rx_next : rx_sh_r;
    assign rx_fmt  = w16 ? rx_word : {8'h00, rx_word[7:0]};

    always_ff @(posedge clk) begin
        if (rst) begin
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_f;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r    <= IDLE;
            edge_cnt_r <= 5'h00;
            div_cnt_r  <= 8'h00;
            sck_int_r  <= 1'b0;
            tx_sh_r    <= 16'h0000;
            rx_sh_r    <= 16'h0000;
            dout_r     <= 1'b0;
        end else begin
            case (state_r)
                IDLE: begin
                    sck_int_r  <= cpol;
                    div_cnt_r  <= 8'h00;
                    edge_cnt_r <= 5'h00;
                    if (!mst && !cpha) begin
                        dout_r <= bit_sel(tx_buf_r, 4'h0, lsb, w16);
                    end
                    if (m_start) begin
                        state_r <= SHIFT;
                        tx_sh_r <= tx_full_r ? tx_buf_r : 16'h0000;
                        if (!cpha) begin
                            dout_r <= bit_sel(tx_buf_r, 4'h0, lsb, w16);
                        end
                    end else if (s_start) begin
                        // First slave edge is handled in this cycle
                        tx_sh_r    <= tx_full_r ? tx_buf_r : 16'h0000;
                        edge_cnt_r <= 5'h01;
                        state_r    <= frame_end ? IDLE : SHIFT;
                        if (!cpha) begin
                            rx_sh_r <= rx_next;
                        end else begin
                            dout_r <= bit_sel(tx_full_r ? tx_buf_r
                                              : 16'h0000, 4'h0, lsb, w16);
                        end
                    end
                end
                SHIFT: begin
                    if (mst) begin
                        div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
                    end
                    if (!act || (!mst && !selected)) begin
                        state_r <= IDLE;
                    end else if (tick) begin
                        if (mst) begin
                            sck_int_r <= !sck_int_r;
                        end
                        edge_cnt_r <= edge_cnt_r + 5'h01;
                        if (k[0] == cpha) begin
                            rx_sh_r <= rx_next;
                        end else if (k != last_edge) begin
                            dout_r <= bit_sel(tx_sh_r,
                                      cpha ? k[4:1] : k[4:1] + 4'h1,
                                      lsb, w16);
                        end
                        if (frame_end) begin
                            state_r <= IDLE;
                        end
                    end
                end
                default: state_r <= IDLE;
            endcase
        end
    end

    // Buffers and buffer flags
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buf_r  <= 16'h0000;
            tx_full_r <= 1'b0;
        end else begin
            if (wr_data) begin
                tx_buf_r  <= w16 ? writedata[15:0]
                                 : {8'h00, writedata[7:0]};
                tx_full_r <= 1'b1;
            end else if (tx_load) begin
                tx_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_buf_r  <= 16'h0000;
            rx_full_r <= 1'b0;
        end else begin
            if (rx_store) begin
                rx_buf_r  <= rx_fmt;
                rx_full_r <= 1'b1;
            end else if (rd_data) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    // Error flags; a setting event always beats a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            overrun_r   <= 1'b0;
            ovr_armed_r <= 1'b0;
        end else begin
            if (frame_end && rx_full_r) begin
                overrun_r <= 1'b1;
            end else if (rd_stat && ovr_armed_r) begin
                overrun_r <= 1'b0;
            end
            if (rd_data) begin
                ovr_armed_r <= 1'b1;
            end else if (rd_stat) begin
                ovr_armed_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            underrun_r <= 1'b0;
        end else if (s_start && i2s && !i2s_ctl_r[BIT_I2S_RX]
                     && !tx_full_r) begin
            underrun_r <= 1'b1;
        end else if (rd_stat) begin
            underrun_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_fault_r <= 1'b0;
            cfg_armed_r <= 1'b0;
        end else begin
            if (fault_cond) begin
                cfg_fault_r <= 1'b1;
            end else if (wr_main && cfg_armed_r) begin
                cfg_fault_r <= 1'b0;
            end
            if (rd_stat || wr_stat) begin
                cfg_armed_r <= 1'b1;
            end else if (wr_main) begin
                cfg_armed_r <= 1'b0;
            end
        end
    end

    logic crc_frame;
    assign crc_frame = frame_end && !i2s && main_ctl_r[BIT_CRC_EN]
                       && main_ctl_r[BIT_CRC_NEXT];
    always_ff @(posedge clk) begin
        if (rst) begin
            crc_err_r <= 1'b0;
        end else if (crc_frame && rx_fmt != crc_calc) begin
            crc_err_r <= 1'b1;
        end else if (wr_stat && byteenable[0]
                     && !writedata[BIT_CRC_ERR]) begin
            crc_err_r <= 1'b0;
        end
    end

    // Master toggles sides itself; slave follows word select
    always_ff @(posedge clk) begin
        if (rst || !i2s || !act) begin
            channel_r <= 1'b0;
        end else if (i2s_ctl_r[BIT_I2S_RX] ? rx_store : tx_load) begin
            channel_r <= mst ? !channel_r : ws_f;
        end
    end

    logic [15:0] i2s_merge;
    assign i2s_merge = lane_merge({4'h0, i2s_ctl_r}, writedata, byteenable);

    // Control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            main_ctl_r <= MAIN_CTL_RESET;
        end else if (wr_main) begin
            main_ctl_r <= lane_merge(main_ctl_r, writedata, byteenable);
        end else if (crc_frame) begin
            main_ctl_r[BIT_CRC_NEXT] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ctl_r <= IRQ_CTL_RESET;
            i2s_ctl_r <= I2S_CTL_RESET;
        end else begin
            if (wr_irq && byteenable[0]) begin
                irq_ctl_r <= writedata[7:0] & IRQ_CTL_MASK;
            end
            if (wr_i2s) begin
                i2s_ctl_r <= i2s_merge[11:0] & I2S_CTL_MASK;
            end
        end
    end

    // Avalon slave: one wait cycle, data latched before release
    logic [7:0] status;
    logic       busy;
    assign busy   = state_r == SHIFT;
    assign status = {busy, overrun_r, cfg_fault_r, crc_err_r,
                     underrun_r, channel_r, !tx_full_r, rx_full_r};

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= !((read || write) && wait_r);
            if (read && wait_r) begin
                case (address)
                    OFS_MAIN_CTL: rdata_r <= {16'h0000, main_ctl_r};
                    OFS_IRQ_CTL:  rdata_r <= {24'h000000, irq_ctl_r};
                    OFS_STATUS:   rdata_r <= {24'h000000, status};
                    OFS_DATA:     rdata_r <= {16'h0000, rx_buf_r};
                    OFS_RX_CRC:   rdata_r <= {16'h0000, crc_calc};
                    OFS_I2S_CTL:  rdata_r <= {20'h00000, i2s_ctl_r};
                    default:      rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pins and interrupt, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            pins_r <= '0;
            irq_r  <= 1'b0;
        end else begin
            pins_r.sck_out  <= mst ? sck_int_r : cpol;
            pins_r.sck_oe   <= act && mst;
            pins_r.mosi_out <= dout_r;
            pins_r.miso_out <= dout_r;
            pins_r.mosi_oe  <= act && !rx_only && out_on_mosi;
            pins_r.miso_oe  <= act && !rx_only && !out_on_mosi
                               && selected;
            irq_r <= (irq_ctl_r[BIT_TXE_IE] && !tx_full_r)
                  || (irq_ctl_r[BIT_RXNE_IE] && rx_full_r)
                  || (irq_ctl_r[BIT_ERR_IE] && (crc_err_r || cfg_fault_r
                      || overrun_r || underrun_r));
        end
    end

    assign readdata    = rdata_r;
    assign waitrequest = wait_r;
    assign pins_out    = pins_r;
    assign irq         = irq_r;
endmodule : spi_ctl

`default_nettype wire

/* test/spi_far_model.sv */
// Far-side SPI slave answering in clock mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_far_model (
    input  wire logic       clk,
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    output logic [7:0]      got,
    output logic [7:0]      half
);
    logic       sck_d = 1'b0;
    logic [2:0] cnt   = 3'h0;
    logic [7:0] tx    = 8'ha5;
    logic [7:0] gap   = 8'h00;
    // Echo of the last word shows which frame a read returns
    assign miso = tx[7];
    always @(posedge clk) begin
        sck_d <= sck;
        gap <= gap + 8'h01;
        if (sck === 1'b1 && sck_d === 1'b0) begin
            got <= {got[6:0], mosi};
            cnt <= cnt + 3'h1;
        end
        if (sck === 1'b0 && sck_d === 1'b1) begin
            tx <= (cnt == 3'h0) ? got : {tx[6:0], 1'b0};
        end
        if (sck !== sck_d) begin
            half <= gap + 8'h01;
            gap <= 8'h00;
        end
    end
endmodule : spi_far_model
`default_nettype wire

/* test/spi_ctl_monitor.sv */
// Bus and reset checks on the serial unit ports
`timescale 1ns/1ps
`default_nettype none
module spi_ctl_monitor
    import spi_ctl_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire pins_out_t   pins_out,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_accept_one_cycle: assert property (!waitrequest |=> waitrequest)
        else $error("accept held too long");
    a_request_answered: assert property
        ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
        else $error("request not answered");
    a_accept_needs_req: assert property (!waitrequest |-> $past(read || write))
        else $error("accept without request");
    a_unmapped_zero: assert property
        (read && !waitrequest && address == 8'h20 |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_half_zero: assert property
        (read && !waitrequest |-> readdata[31:16] == 16'h0)
        else $error("upper half not zero");
    a_status_top_zero: assert property (read && !waitrequest
        && address == OFS_STATUS |-> readdata[15:8] == 8'h0)
        else $error("status reserved bits set");
    a_rdata_hold: assert property ($changed(readdata) |-> read && !waitrequest)
        else $error("read data moved");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !irq && pins_out == '0 && waitrequest)
        else $error("outputs active in reset");
endmodule : spi_ctl_monitor
`default_nettype wire
bind spi_ctl spi_ctl_monitor i_spi_ctl_monitor (
    .clk(clk),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .pins_out(pins_out),
    .irq(irq)
);

/* test/tb_top.sv */
// Self-checking bench for the serial control unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import spi_ctl_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    pins_out_t   pins_out;
    logic        irq;
    logic        nss_pin = 1'b0;
    logic        miso;
    logic [7:0]  got;
    logic [7:0]  half;
    logic [31:0] q;
    pins_in_t    pin;
    int          n_mismatch = 0;
    int          n_compared = 0;
    assign pin = '{1'b0, 1'b0, miso, nss_pin, 1'b0};
    always #2 clk = ~clk;
    spi_ctl i_spi_ctl (.clk(clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(4'h3), .readdata(readdata),
        .waitrequest(waitrequest), .pins_in(pin), .pins_out(pins_out),
        .crc_calc(16'h0), .irq(irq));
    spi_far_model i_spi_far_model (.clk(clk), .sck(pins_out.sck_out),
        .mosi(pins_out.mosi_out), .miso(miso), .got(got), .half(half));
    task wrap_up;
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            n_mismatch++;
        end
    endtask : chk
    // Request held until the edge that samples waitrequest low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (waitrequest !== 1'b0 && i < 50);
        if (waitrequest !== 1'b0) begin
            chk(32'h0, 32'h1);
            wrap_up();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task poll(input int b);
        int k;
        for (k = 0; k < 300; k++) begin
            bus(1'b0, OFS_STATUS, 32'h0);
            if (q[b] === 1'b1) return;
        end
        chk(32'h0, 32'h1);
        wrap_up();
    endtask : poll
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h2);
        bus(1'b0, OFS_MAIN_CTL, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, OFS_IRQ_CTL, 32'h80);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, OFS_IRQ_CTL, 32'h20);
        bus(1'b1, OFS_MAIN_CTL, 32'h44);
        poll(BIT_CFG_FAULT);
        chk({31'h0, irq}, 32'h1);
        // Soft select high, prescaler 3: half period of eight clocks
        bus(1'b1, OFS_MAIN_CTL, 32'h35c);
        // Fault still stands in the cycle of the write that cures it
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h22);
        bus(1'b1, OFS_MAIN_CTL, 32'h35c);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h2);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, OFS_DATA, 32'h3c);
        poll(BIT_BUSY);
        poll(BIT_RX_NEMPTY);
        bus(1'b0, OFS_DATA, 32'h0);
        chk(q, 32'ha5);
        chk({24'h0, got}, 32'h3c);
        chk({24'h0, half}, 32'h8);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h2);
        bus(1'b1, OFS_DATA, 32'h11);
        poll(BIT_RX_NEMPTY);
        bus(1'b1, OFS_DATA, 32'h22);
        poll(BIT_OVERRUN);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, OFS_DATA, 32'h0);
        chk(q, 32'h3c);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h40, 32'h40);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h2);
        // Computed CRC is tied to zero, so a nonzero echo must mismatch
        bus(1'b1, OFS_MAIN_CTL, 32'h335c);
        bus(1'b1, OFS_DATA, 32'h33);
        poll(BIT_CRC_ERR);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, OFS_MAIN_CTL, 32'h0);
        chk(q, 32'h235c);
        bus(1'b1, OFS_STATUS, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h3);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
